/* File: hdl/hdbp_pkg.sv */
package hdbp_pkg;

   localparam int HDBP_ADDR_W   = 8;
   localparam int HDBP_DATA_W   = 8;
   localparam int HDBP_FIFO_D   = 16;

   // Pin levels of the bus style select strap.
   localparam logic HDBP_STYLE_DS = 1'b1;
   localparam logic HDBP_STYLE_RW = 1'b0;

   // Direction line levels for a normal-mode DMA transfer.
   localparam logic HDBP_DIR_WRITE = 1'b0;
   localparam logic HDBP_DIR_READ  = 1'b1;

   localparam logic [HDBP_DATA_W-1:0] HDBP_DATA_RST = 8'h00;
   localparam logic [HDBP_ADDR_W-1:0] HDBP_ADDR_RST = 8'h00;

   typedef enum logic
   {
      HDBP_ACC_READ,
      HDBP_ACC_WRITE
   } hdbp_dir_t;

   // One completed register write or register read request.
   typedef struct packed
   {
      logic                   write;
      logic [HDBP_ADDR_W-1:0] addr;
      logic [HDBP_DATA_W-1:0] data;
   } hdbp_reg_req_t;

endpackage : hdbp_pkg

/* File: hdl/hdbp_fifo.sv */
`timescale 1ns/1ps
module hdbp_fifo
   import hdbp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem_q[rd_q];

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : hdbp_fifo

/* File: hdl/hdbp_port.sv */
`timescale 1ns/1ps
// Behaviour
// - Register access needs address and low chip select; DMA cycles excepted.
// - Style pin high selects data strobe style, low separate strobes.
// - Style pin captured at reset release, held until next reset.
// - Data strobe style uses only separate address and data buses.
// - Separate strobe style muxing follows how host drives address latch.
// - Data strobe style: direction line picks read or write, strobe times.
// - Data strobe register access active only while strobe and chip select low.
// - Separate strobe DMA: which strobe is low picks read or write.
// - Normal DMA: write strobe is transmit write, read strobe receive read.
// - Fly-by DMA inverts strobe meaning versus normal DMA.
// - DMA acknowledge alone marks a DMA cycle; chip select not needed.
// - Normal or fly-by DMA is a control setting, independent of style pin.
// - Normal data strobe DMA: direction low writes, high reads; fly-by inverts.
module hdbp_port
   import hdbp_pkg::*;
#(
   parameter int FIFO_DEPTH = HDBP_FIFO_D
)
(
   input  wire logic                   i_clk,
   input  wire logic                   i_sys_rst,
   input  wire logic                   i_bus_style,
   input  wire logic                   i_fly_by,
   input  wire logic                   i_chip_select_n,
   input  wire logic                   i_data_strobe_n,
   input  wire logic                   i_read_write,
   input  wire logic                   i_read_n,
   input  wire logic                   i_write_n,
   input  wire logic                   i_addr_latch_en,
   input  wire logic                   i_dma_acknowledge_n,
   input  wire logic [HDBP_ADDR_W-1:0] i_addr,
   input  wire logic [HDBP_DATA_W-1:0] i_data,
   output logic      [HDBP_DATA_W-1:0] o_data,
   output logic                        o_data_oe,
   output logic                        o_dma_transmit_request,
   output logic                        o_dma_receive_request,
   input  wire logic                   i_tx_space,
   input  wire logic                   i_rx_avail,
   input  wire logic [HDBP_DATA_W-1:0] i_rx_data,
   output logic                        o_rx_taken,
   output logic                        o_tx_valid,
   input  wire logic                   i_tx_ready,
   output logic      [HDBP_DATA_W-1:0] o_tx_data,
   output logic                        o_reg_valid,
   output hdbp_reg_req_t               o_reg_req,
   input  wire logic [HDBP_DATA_W-1:0] i_reg_rdata,
   output logic                        o_style_ds
);

   // Control pins, strobes and buses are synchronised by two flip-flops.
   localparam int SN = 7;
   logic [SN-1:0]          s1_q;
   logic [SN-1:0]          s2_q;
   logic [HDBP_ADDR_W-1:0] a1_q;
   logic [HDBP_ADDR_W-1:0] a2_q;
   logic [HDBP_DATA_W-1:0] d1_q;
   logic [HDBP_DATA_W-1:0] d2_q;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         s1_q <= 7'h7F;
         s2_q <= 7'h7F;
         a1_q <= HDBP_ADDR_RST;
         a2_q <= HDBP_ADDR_RST;
         d1_q <= HDBP_DATA_RST;
         d2_q <= HDBP_DATA_RST;
      end
      else
      begin
         s1_q <= {i_bus_style, i_chip_select_n, i_data_strobe_n,
                  i_read_write, i_read_n, i_write_n,
                  i_dma_acknowledge_n};
         s2_q <= s1_q;
         a1_q <= i_addr;
         a2_q <= a1_q;
         d1_q <= i_data;
         d2_q <= d1_q;
      end
   end

   logic style_pin;
   logic cs_n;
   logic ds_n;
   logic rw;
   logic rd_n;
   logic wr_n;
   logic dma_acknowledge_n_n;
   logic ale_q;
   logic ale1_q;

   assign {style_pin, cs_n, ds_n, rw, rd_n, wr_n, dma_acknowledge_n_n} = s2_q;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ale1_q <= 1'b1;
         ale_q  <= 1'b1;
      end
      else
      begin
         ale1_q <= i_addr_latch_en;
         ale_q  <= ale1_q;
      end
   end

   // The strap is taken once the synchroniser holds the pin, not its reset.
   logic       style_q;
   logic       strap_done_q;
   logic [1:0] strap_cnt_q;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         style_q      <= HDBP_STYLE_DS;
         strap_done_q <= 1'b0;
         strap_cnt_q  <= 2'h0;
      end
      else if (!strap_done_q)
      begin
         if (strap_cnt_q == 2'h2)
         begin
            style_q      <= (style_pin == HDBP_STYLE_DS);
            strap_done_q <= 1'b1;
         end
         else
         begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
      end
   end

   // Address latch: with the latch enable held high the bus is transparent,
   // otherwise the address is captured from the shared bus while it is high.
   logic [HDBP_ADDR_W-1:0] lat_addr_q;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         lat_addr_q <= HDBP_ADDR_RST;
      end
      else if (ale_q)
      begin
         lat_addr_q <= (style_q == HDBP_STYLE_RW) ? d2_q : a2_q;
      end
   end

   logic [HDBP_ADDR_W-1:0] acc_addr;
   logic                   demux;
   assign demux    = (style_q == HDBP_STYLE_DS) || ale_q;
   assign acc_addr = demux ? a2_q : lat_addr_q;

   // Cycle decode.
   logic dma_cyc;
   logic reg_act;
   logic act_rd;
   logic act_wr;
   logic dma_rd;
   logic dma_wr;

   always_comb
   begin
      dma_cyc = !dma_acknowledge_n_n;
      act_rd  = 1'b0;
      act_wr  = 1'b0;
      if (style_q == HDBP_STYLE_DS)
      begin
         act_rd = !ds_n && (rw == HDBP_DIR_READ);
         act_wr = !ds_n && (rw == HDBP_DIR_WRITE);
         if (dma_cyc && i_fly_by)
         begin
            act_rd = !ds_n && (rw == HDBP_DIR_WRITE);
            act_wr = !ds_n && (rw == HDBP_DIR_READ);
         end
      end
      else
      begin
         act_rd = !rd_n && wr_n;
         act_wr = !wr_n && rd_n;
         if (dma_cyc && i_fly_by)
         begin
            act_rd = !wr_n && rd_n;
            act_wr = !rd_n && wr_n;
         end
      end
      reg_act = !dma_cyc && !cs_n && (act_rd || act_wr);
      dma_rd  = dma_cyc && act_rd;
      dma_wr  = dma_cyc && act_wr;
   end

   // Each read is acted on once, at its start; a write is acted on at its end, seen on release.
   logic busy_q;
   logic pend_wr_q;
   logic any_act;
   assign any_act = reg_act || dma_rd || dma_wr;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         busy_q    <= 1'b0;
         pend_wr_q <= 1'b0;
      end
      else
      begin
         busy_q    <= any_act;
         pend_wr_q <= any_act && act_wr;
      end
   end

   logic start;
   logic wr_end;
   assign start  = any_act && !busy_q;
   assign wr_end = pend_wr_q && !any_act;

   // Write data is kept while the strobe is low, since the host may release
   // the bus right as the strobe rises.
   logic wr_dma_q;
   logic [HDBP_ADDR_W-1:0] wr_addr_q;
   logic [HDBP_DATA_W-1:0] wr_data_q;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wr_dma_q  <= 1'b0;
         wr_addr_q <= HDBP_ADDR_RST;
         wr_data_q <= HDBP_DATA_RST;
      end
      else
      begin
         if (start)
         begin
            wr_dma_q  <= dma_wr;
            wr_addr_q <= acc_addr;
         end
         if (any_act && act_wr)
         begin
            wr_data_q <= d2_q;
         end
      end
   end

   // Transmit data from DMA writes passes the FIFO.
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [HDBP_DATA_W-1:0] fifo_out_data;
   logic                   tx_pop;

   // The output register is refilled whenever it is empty or being taken.
   assign tx_pop = fifo_out_valid && (!o_tx_valid || i_tx_ready);

   hdbp_fifo #(
      .WIDTH (HDBP_DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (wr_end && wr_dma_q),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (wr_data_q),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (tx_pop),
      .o_out_data  (fifo_out_data)
   );

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_tx_valid             <= 1'b0;
         o_tx_data              <= HDBP_DATA_RST;
         o_dma_transmit_request <= 1'b0;
         o_dma_receive_request  <= 1'b0;
         o_style_ds             <= HDBP_STYLE_DS;
      end
      else
      begin
         o_tx_valid <= tx_pop || (o_tx_valid && !i_tx_ready);
         o_tx_data  <= tx_pop ? fifo_out_data : o_tx_data;
         // Requests drop as soon as a transfer starts, so one is served each.
         o_dma_transmit_request <= fifo_in_ready && i_tx_space && !dma_wr;
         o_dma_receive_request  <= i_rx_avail && !dma_rd;
         o_style_ds             <= style_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_reg_valid <= 1'b0;
         o_reg_req   <= '0;
         o_rx_taken  <= 1'b0;
      end
      else
      begin
         o_reg_valid     <= (wr_end && !wr_dma_q) || (start && reg_act &&
                            act_rd);
         o_reg_req.write <= wr_end;
         o_reg_req.addr  <= wr_end ? wr_addr_q : acc_addr;
         o_reg_req.data  <= wr_data_q;
         o_rx_taken      <= start && dma_rd;
      end
   end

   // Read data drive.
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_data    <= HDBP_DATA_RST;
         o_data_oe <= 1'b0;
      end
      else
      begin
         o_data_oe <= (reg_act && act_rd) || dma_rd;
         o_data    <= dma_rd ? i_rx_data : i_reg_rdata;
      end
   end

   chk_oe_follows_read: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_data_oe |-> $past(act_rd))
      else $error("data bus driven outside a read");

   chk_no_cs_no_reg: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (cs_n && dma_acknowledge_n_n) |=> !o_reg_valid && !o_data_oe)
      else $error("access without chip select");

   chk_style_held: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      strap_done_q |=> $stable(style_q))
      else $error("bus style changed after reset");

   chk_flyby_ds_read: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (style_q && !dma_acknowledge_n_n && i_fly_by && !ds_n && !rw) |=> o_data_oe)
      else $error("fly-by read not driven");

   chk_normal_rw_wr: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (!style_q && !dma_acknowledge_n_n && !i_fly_by && !wr_n && rd_n) |=> !o_data_oe)
      else $error("normal DMA write drove the bus");

   chk_flyby_rw_rd: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (!style_q && !dma_acknowledge_n_n && i_fly_by && !wr_n && rd_n) |=> o_data_oe)
      else $error("fly-by DMA read not driven");

   chk_dma_no_reg: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (!dma_acknowledge_n_n && !busy_q) |=> !o_reg_valid)
      else $error("DMA cycle seen as register access");

   chk_ds_needs_cs: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (style_q && dma_acknowledge_n_n && (ds_n || cs_n)) |=> !o_data_oe)
      else $error("access active without strobe and select");

endmodule : hdbp_port

/* File: sim/hdbp_host_model.sv */
`timescale 1ns/1ps
module hdbp_host_model
   import hdbp_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_style_ds,
   input  wire logic                   i_fly_by,
   input  wire logic                   i_mux,
   input  wire logic                   i_dev_oe,
   input  wire logic [HDBP_DATA_W-1:0] i_dev_data,
   output wire logic [HDBP_DATA_W-1:0] o_data,
   output logic      [HDBP_ADDR_W-1:0] o_addr,
   output logic                        o_cs_n,
   output logic                        o_strobe_n,
   output logic                        o_rw,
   output logic                        o_rd_n,
   output logic                        o_wr_n,
   output logic                        o_ale,
   output logic                        o_ack_n
);
   logic                   drv = 1'b0;
   logic [HDBP_DATA_W-1:0] val = 8'h00;
   logic [HDBP_DATA_W-1:0] last = 8'h00;

   // A released bus toggles every cycle so a stale value never matches.
   assign o_data = drv ? val : (i_dev_oe ? i_dev_data : ~last);

   always @(posedge i_clk)
   begin
      last <= o_data;
   end

   initial
   begin
      o_addr = 8'h00;
      {o_cs_n, o_strobe_n, o_rw, o_rd_n, o_wr_n, o_ale, o_ack_n} = 7'h7F;
   end

   task automatic access(input logic dma, input logic wr, input logic sel,
                         input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      logic use_rd;
      use_rd = (dma && i_fly_by) ? wr : !wr;
      @(posedge i_clk);
      #5;
      o_addr = a;
      if (i_mux && !i_style_ds)
      begin
         o_addr = ~a;
         val = a;
         drv = 1'b1;
         repeat (3) @(posedge i_clk);
         #5;
         o_ale = 1'b0;
         repeat (2) @(posedge i_clk);
         #5;
      end
      o_cs_n = !(sel && !dma);
      o_ack_n = !(sel && dma);
      drv = wr;
      val = d;
      o_rw = use_rd;
      @(posedge i_clk);
      #5;
      o_strobe_n = !i_style_ds;
      o_rd_n = i_style_ds | !use_rd;
      o_wr_n = i_style_ds | use_rd;
      repeat (5) @(posedge i_clk);
      q = o_data;
      #5;
      {o_strobe_n, o_rd_n, o_wr_n} = 3'h7;
      drv = 1'b0;
      repeat (3) @(posedge i_clk);
      #5;
      {o_cs_n, o_ack_n} = 2'h3;
      o_ale = 1'b1;
      repeat (3) @(posedge i_clk);
      #5;
   endtask : access
endmodule : hdbp_host_model

/* File: sim/tb_hdbp_port.sv */
`timescale 1ns/1ps
module tb_hdbp_port;
   import hdbp_pkg::*;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   style = 1'b1;
   logic                   fly = 1'b0;
   logic                   mux = 1'b0;
   logic                   rx_avail = 1'b1;
   logic                   tx_ready = 1'b1;
   logic [HDBP_DATA_W-1:0] rx_data = 8'h00;
   logic [HDBP_DATA_W-1:0] rdata = 8'h00;
   wire  [HDBP_DATA_W-1:0] bus;
   wire  [HDBP_ADDR_W-1:0] addr;
   wire                    cs_n, strobe_n, rw, rd_n, wr_n, ale, ack_n;
   logic [HDBP_DATA_W-1:0] dout, tx_data;
   logic                   oe, txr, rxr, rx_taken, tx_valid;
   logic                   reg_valid, style_ds;
   hdbp_reg_req_t          req, got;
   logic [15:0]            seed = 16'hE5FE;
   logic [7:0]             q, a, d;
   logic [7:0]             txq[$];
   logic [7:0]             expq[$];
   int                     errors = 0;
   int                     cmp_count = 0;
   int                     n_req = 0;
   int                     n_rx = 0;
   int                     n0;

   always #25 clk = ~clk;

   hdbp_port #(.FIFO_DEPTH(HDBP_FIFO_D)) DUT (
      .i_clk(clk), .i_sys_rst(rst), .i_bus_style(style), .i_fly_by(fly),
      .i_chip_select_n(cs_n), .i_data_strobe_n(strobe_n),
      .i_read_write(rw), .i_read_n(rd_n), .i_write_n(wr_n),
      .i_addr_latch_en(ale), .i_dma_acknowledge_n(ack_n), .i_addr(addr),
      .i_data(bus), .o_data(dout), .o_data_oe(oe),
      .o_dma_transmit_request(txr), .o_dma_receive_request(rxr),
      .i_tx_space(1'b1), .i_rx_avail(rx_avail), .i_rx_data(rx_data),
      .o_rx_taken(rx_taken), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
      .o_tx_data(tx_data), .o_reg_valid(reg_valid), .o_reg_req(req),
      .i_reg_rdata(rdata), .o_style_ds(style_ds));

   hdbp_host_model host (
      .i_clk(clk), .i_style_ds(style_ds), .i_fly_by(fly), .i_mux(mux),
      .i_dev_oe(oe), .i_dev_data(dout), .o_data(bus), .o_addr(addr),
      .o_cs_n(cs_n), .o_strobe_n(strobe_n), .o_rw(rw), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_ale(ale), .o_ack_n(ack_n));

   always @(posedge clk)
   begin
      if (reg_valid === 1'b1)
      begin
         got <= req;
         n_req <= n_req + 1;
      end
      if (rx_taken === 1'b1)
         n_rx <= n_rx + 1;
      if (tx_valid === 1'b1 && tx_ready)
         txq.push_back(tx_data);
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic logic [16:0] exp_req(input logic w,
                                           input logic [7:0] ea,
                                           input logic [7:0] ed);
      return {w, ea, ed};
   endfunction : exp_req

   task automatic cmp_val(input logic [16:0] g, input logic [16:0] e);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp_val

   task automatic roll();
      seed = lfsr(seed);
      a = seed[7:0];
      d = seed[15:8];
   endtask : roll

   task automatic summarize();
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic run_style(input logic s);
      rst = 1'b1;
      style = s;
      repeat (4) @(posedge clk);
      #5;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #5;
      cmp_val(17'(style_ds), 17'(s));
      style = !s;
      for (int m = 0; m < 2; m++)
      begin
         mux = m[0] & !s;
         for (int i = 0; i < 3; i++)
         begin
            roll();
            n0 = n_req;
            host.access(1'b0, 1'b1, 1'b1, a, d, q);
            cmp_val(got, exp_req(1'b1, a, d));
            cmp_val(17'(n_req - n0), 17'h1);
            rdata = d ^ a;
            host.access(1'b0, 1'b0, 1'b1, a, 8'h00, q);
            cmp_val(17'(q), 17'(rdata));
            cmp_val(17'(got.addr), 17'(a));
            cmp_val(17'(oe), 17'h0);
            n0 = n_req;
            host.access(1'b0, 1'b1, 1'b0, a, d, q);
            cmp_val(17'(n_req - n0), 17'h0);
         end
      end
      mux = 1'b0;
      for (int f = 0; f < 2; f++)
      begin
         fly = f[0];
         roll();
         host.access(1'b1, 1'b1, 1'b1, a, d, q);
         cmp_val(17'(txq.size()), 17'h1);
         cmp_val(17'(txq.pop_front()), 17'(d));
         rx_data = a;
         n0 = n_rx;
         host.access(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, q);
         cmp_val(17'(q), 17'(rx_data));
         cmp_val(17'(n_rx - n0), 17'h1);
      end
      fly = 1'b0;
      cmp_val(17'(style_ds), 17'(s));
   endtask : run_style

   initial
   begin
      run_style(1'b1);
      run_style(1'b0);
      tx_ready = 1'b0;
      for (int i = 0; i <= HDBP_FIFO_D + 1; i++)
      begin
         roll();
         if (i <= HDBP_FIFO_D)
            expq.push_back(d);
         host.access(1'b1, 1'b1, 1'b1, a, d, q);
      end
      cmp_val(17'(txr), 17'h0);
      tx_ready = 1'b1;
      for (int k = 0; k < 60 && txq.size() <= HDBP_FIFO_D; k++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      #5;
      cmp_val(17'(txq.size()), 17'(HDBP_FIFO_D + 1));
      foreach (expq[i])
         cmp_val(17'(txq[i]), 17'(expq[i]));
      cmp_val(17'(txr), 17'h1);
      rx_avail = 1'b0;
      repeat (4) @(posedge clk);
      #5;
      cmp_val(17'(rxr), 17'h0);
      rx_avail = 1'b1;
      repeat (4) @(posedge clk);
      #5;
      cmp_val(17'(rxr), 17'h1);
      summarize();
   end

   initial
   begin
      #300000;
      errors++;
      summarize();
   end
endmodule : tb_hdbp_port
